// >>> src/gpio_pin_config_bank.sv
// Pin configuration bank for general-purpose pins 3, 5, 6, 7 and 8, primary and alternate sets.
// Assumes one AHB-Lite master, synchronous pin inputs and a single clock hclk.
//
// Overview of operation
// - In GPIO mode with output direction and remote control off, a pin drives its local value.
// - With remote control set, a pin is forced to output and drives the remote serializer value.
// - With remote control clear, remote values are ignored and only local settings count.
// - Direction-enable code 00 selects the normal function as output and 10 floats the pin.
// - Code 01 selects GPIO output and code 11 selects GPIO input.
// - The pin 5/6 register holds pin 6 in bits 7..4 and pin 5 in bits 3..0, reset to zero.
// - The pin 7/8 register holds pin 8 in bits 7..4, pin 7 in bits 3..1 and a reserved bit 0.
// - Pin 3 direction is bit 1 and enable bit 0, resetting to 0 locally and to 1 for the alternate.
// - With the second-port select set, the registers reach the alternate pin set instead.

`timescale 1ns/1ps
`default_nettype none

`include "gpio_pin_regs.svh"

// ****************************************************************
// Per-pin drive decision
// ****************************************************************

module gpio_pin_cell (
   input wire logic hclk, // Bus clock.
   input wire logic hresetn, // Asynchronous reset, active low.
   input wire gpio_pin_pkg::pin_cfg_t cfg, // Value, remote, direction, enable.
   input wire logic func_value, // Normal function output value.
   input wire logic remote_value, // Value mirrored from the remote serializer.
   output logic pin_out, // Registered pin output level.
   output logic pin_oe // Registered pin output enable.
);

   gpio_pin_pkg::pin_mode_e mode;
   logic next_out;
   logic next_oe;

   always_comb begin
      unique case ({cfg[`FLD_DIR], cfg[`FLD_EN]})
         `CODE_FUNCTIONAL: mode = gpio_pin_pkg::mode_functional;
         `CODE_TRISTATE: mode = gpio_pin_pkg::mode_tristate;
         `CODE_GPIO_OUT: mode = gpio_pin_pkg::mode_gpio_out;
         `CODE_GPIO_IN: mode = gpio_pin_pkg::mode_gpio_in;
      endcase
   end

   always_comb begin
      next_out = 1'b0;
      next_oe = 1'b0;
      if (cfg[`FLD_REMOTE]) begin
         // Remote control overrides direction and enable.
         next_out = remote_value;
         next_oe = 1'b1;
      end else begin
         // Remote value is not looked at on this path.
         unique case (mode)
            gpio_pin_pkg::mode_functional: begin
               next_out = func_value;
               next_oe = 1'b1;
            end
            gpio_pin_pkg::mode_gpio_out: begin
               next_out = cfg[`FLD_VALUE];
               next_oe = 1'b1;
            end
            gpio_pin_pkg::mode_tristate: begin
               next_oe = 1'b0;
            end
            gpio_pin_pkg::mode_gpio_in: begin
               next_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_out <= 1'b0;
         pin_oe <= 1'b0;
      end else begin
         pin_out <= next_out;
         pin_oe <= next_oe;
      end
   end

endmodule

// ****************************************************************
// Register bank and pin sets
// ****************************************************************

module gpio_pin_config_bank (
   input wire logic hclk, // Bus clock, 50 MHz.
   input wire logic hresetn, // Asynchronous reset, active low.
   input wire logic hsel, // Slave select.
   input wire logic [31:0] haddr, // Byte address.
   input wire logic [1:0] htrans, // Transfer type.
   input wire logic hwrite, // Write when high.
   input wire logic [2:0] hsize, // Transfer size, word only.
   input wire logic [31:0] hwdata, // Write data.
   input wire logic hready, // Bus ready.
   output logic hreadyout, // Slave ready.
   output logic hresp, // Response, always OKAY.
   output logic [31:0] hrdata, // Read data.
   input wire logic [4:0] func_value, // Normal function values, primary set.
   input wire logic [4:0] alt_func_value, // Normal function values, alternate set.
   input wire logic [4:0] remote_value, // Values mirrored from the serializer.
   input wire logic [4:0] pin_in, // Primary pin levels.
   output logic [4:0] pin_out, // Primary pin output levels.
   output logic [4:0] pin_oe, // Primary pin output enables.
   input wire logic [4:0] alt_pin_in, // Alternate pin levels.
   output logic [4:0] alt_pin_out, // Alternate pin output levels.
   output logic [4:0] alt_pin_oe // Alternate pin output enables.
);

   logic [7:0] pin3_ctrl [2];
   logic [7:0] pin_pair_5_6_control [2];
   logic [7:0] pin_pair_7_8_control [2];
   logic [7:0] port_ctrl;
   logic second_port_select;
   logic bank;
   logic addr_ok;
   logic [7:0] addr_index;
   logic accept;
   logic wr_pending;
   logic [7:0] wr_index;
   logic [7:0] read_byte;
   logic [4:0] status_bits;
   gpio_pin_pkg::pin_cfg_t cfg [2][`PIN_COUNT];
   logic [4:0] func_set [2];
   logic [4:0] out_set [2];
   logic [4:0] oe_set [2];

   // ****************************************************************
   // Bus slave
   // ****************************************************************

   // Every transfer completes with no wait state.
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   assign second_port_select = port_ctrl[`PORT_SEL_BIT];
   assign bank = second_port_select;
   assign addr_index = haddr[9:2];
   assign addr_ok = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'b00);
   assign accept = hsel && hready && htrans[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pending <= 1'b0;
         wr_index <= 8'h00;
      end else begin
         wr_pending <= accept && hwrite && addr_ok;
         wr_index <= addr_index;
      end
   end

   // ****************************************************************
   // Configuration registers
   // ****************************************************************

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin3_ctrl[0] <= `PIN3_CTRL_RESET;
         pin3_ctrl[1] <= `ALT_PIN3_CTRL_RESET;
      end else if (wr_pending && wr_index == `PIN3_CTRL_INDEX) begin
         pin3_ctrl[bank] <= hwdata[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_pair_5_6_control[0] <= `PAIR_CTRL_RESET;
         pin_pair_5_6_control[1] <= `PAIR_CTRL_RESET;
      end else if (wr_pending && wr_index == `PAIR56_CTRL_INDEX) begin
         pin_pair_5_6_control[bank] <= hwdata[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_pair_7_8_control[0] <= `PAIR_CTRL_RESET;
         pin_pair_7_8_control[1] <= `PAIR_CTRL_RESET;
      end else if (wr_pending && wr_index == `PAIR78_CTRL_INDEX) begin
         pin_pair_7_8_control[bank] <= hwdata[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         port_ctrl <= `PORT_CTRL_RESET;
      end else if (wr_pending && wr_index == `PORT_CTRL_INDEX) begin
         port_ctrl <= {7'h00, hwdata[`PORT_SEL_BIT]};
      end
   end

   // ****************************************************************
   // Read path
   // ****************************************************************

   assign status_bits = second_port_select ? alt_pin_in : pin_in;

   always_comb begin
      read_byte = 8'h00;
      if (addr_ok) begin
         case (addr_index)
            `PIN3_CTRL_INDEX: read_byte = pin3_ctrl[bank];
            `PAIR56_CTRL_INDEX: read_byte = pin_pair_5_6_control[bank];
            `PAIR78_CTRL_INDEX: read_byte = pin_pair_7_8_control[bank];
            `PORT_CTRL_INDEX: read_byte = port_ctrl;
            `PIN_STATUS_INDEX: read_byte = {3'h0, status_bits};
            default: read_byte = 8'h00;
         endcase
      end
   end

   // Read data is captured at the address phase and stands through the data phase.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (accept && !hwrite) begin
         hrdata <= {24'h000000, read_byte};
      end
   end

   // ****************************************************************
   // Named fields of the primary copy and of the alternate pin 3
   // ****************************************************************

   logic pin3_direction;
   logic pin3_enable;
   logic alt_pin3_direction;
   logic alt_pin3_enable;
   logic pin5_local_value;
   logic pin5_remote_ctrl;
   logic pin5_direction;
   logic pin5_enable;
   logic pin6_local_value;
   logic pin6_remote_ctrl;
   logic pin6_direction;
   logic pin6_enable;
   logic pin7_local_value;
   logic pin7_remote_ctrl;
   logic pin7_direction;
   logic pin8_local_value;
   logic pin8_remote_ctrl;
   logic pin8_direction;
   logic pin8_enable;

   assign pin3_direction = pin3_ctrl[0][`FLD_DIR];
   assign pin3_enable = pin3_ctrl[0][`FLD_EN];
   assign alt_pin3_direction = pin3_ctrl[1][`FLD_DIR];
   assign alt_pin3_enable = pin3_ctrl[1][`FLD_EN];
   assign pin5_local_value = pin_pair_5_6_control[0][`FLD_VALUE];
   assign pin5_remote_ctrl = pin_pair_5_6_control[0][`FLD_REMOTE];
   assign pin5_direction = pin_pair_5_6_control[0][`FLD_DIR];
   assign pin5_enable = pin_pair_5_6_control[0][`FLD_EN];
   assign pin6_local_value = pin_pair_5_6_control[0][`HIGH_PIN_LSB + `FLD_VALUE];
   assign pin6_remote_ctrl = pin_pair_5_6_control[0][`HIGH_PIN_LSB + `FLD_REMOTE];
   assign pin6_direction = pin_pair_5_6_control[0][`HIGH_PIN_LSB + `FLD_DIR];
   assign pin6_enable = pin_pair_5_6_control[0][`HIGH_PIN_LSB + `FLD_EN];
   assign pin7_local_value = pin_pair_7_8_control[0][`FLD_VALUE];
   assign pin7_remote_ctrl = pin_pair_7_8_control[0][`FLD_REMOTE];
   assign pin7_direction = pin_pair_7_8_control[0][`FLD_DIR];
   assign pin8_local_value = pin_pair_7_8_control[0][`HIGH_PIN_LSB + `FLD_VALUE];
   assign pin8_remote_ctrl = pin_pair_7_8_control[0][`HIGH_PIN_LSB + `FLD_REMOTE];
   assign pin8_direction = pin_pair_7_8_control[0][`HIGH_PIN_LSB + `FLD_DIR];
   assign pin8_enable = pin_pair_7_8_control[0][`HIGH_PIN_LSB + `FLD_EN];

   // ****************************************************************
   // Field unpacking
   // ****************************************************************

   // Pin 7 has no enable field, so it always sits in GPIO mode.
   always_comb begin
      cfg[0][0] = {pin3_ctrl[0][`FLD_VALUE:`FLD_REMOTE], pin3_direction, pin3_enable};
      cfg[0][1] = {pin5_local_value, pin5_remote_ctrl, pin5_direction, pin5_enable};
      cfg[0][2] = {pin6_local_value, pin6_remote_ctrl, pin6_direction, pin6_enable};
      cfg[0][3] = {pin7_local_value, pin7_remote_ctrl, pin7_direction, 1'b1};
      cfg[0][4] = {pin8_local_value, pin8_remote_ctrl, pin8_direction, pin8_enable};
      cfg[1][0] = {pin3_ctrl[1][`FLD_VALUE:`FLD_REMOTE], alt_pin3_direction, alt_pin3_enable};
      cfg[1][1] = pin_pair_5_6_control[1][3:0];
      cfg[1][2] = pin_pair_5_6_control[1][7:4];
      cfg[1][3] = {pin_pair_7_8_control[1][3:1], 1'b1};
      cfg[1][4] = pin_pair_7_8_control[1][7:4];
   end

   assign func_set[0] = func_value;
   assign func_set[1] = alt_func_value;

   // ****************************************************************
   // Pin cells
   // ****************************************************************

   for (genvar b = 0; b < 2; b++) begin : g_set
      for (genvar p = 0; p < `PIN_COUNT; p++) begin : g_pin
         gpio_pin_cell u_cell (
            .hclk(hclk),
            .hresetn(hresetn),
            .cfg(cfg[b][p]),
            .func_value(func_set[b][p]),
            .remote_value(remote_value[p]),
            .pin_out(out_set[b][p]),
            .pin_oe(oe_set[b][p])
         );
      end
   end

   assign pin_out = out_set[0];
   assign pin_oe = oe_set[0];
   assign alt_pin_out = out_set[1];
   assign alt_pin_oe = oe_set[1];

endmodule

`default_nettype wire

// >>> src/gpio_pin_pkg.sv
// Types shared by the pin configuration bank.
// Assumes nothing beyond a SystemVerilog compiler.
package gpio_pin_pkg;

   typedef enum logic [1:0] {
      mode_functional,
      mode_gpio_out,
      mode_tristate,
      mode_gpio_in
   } pin_mode_e;

   typedef logic [3:0] pin_cfg_t;

endpackage

// >>> src/gpio_pin_regs.svh
// Register indices, field positions, reset values and mode codes of the pin bank.
// Assumes a 32-bit bus where each register takes the word at byte address index * 4.
`ifndef GPIO_PIN_REGS_SVH
`define GPIO_PIN_REGS_SVH

`define PIN3_CTRL_INDEX 8'h1f
`define PAIR56_CTRL_INDEX 8'h20
`define PAIR78_CTRL_INDEX 8'h21
`define PORT_CTRL_INDEX 8'h24
`define PIN_STATUS_INDEX 8'h25

`define PIN3_CTRL_RESET 8'h00
`define ALT_PIN3_CTRL_RESET 8'h03
`define PAIR_CTRL_RESET 8'h00
`define PORT_CTRL_RESET 8'h00

`define FLD_VALUE 3
`define FLD_REMOTE 2
`define FLD_DIR 1
`define FLD_EN 0
`define PORT_SEL_BIT 0
`define PIN_COUNT 5
`define HIGH_PIN_LSB 4

`define CODE_FUNCTIONAL 2'b00
`define CODE_GPIO_OUT 2'b01
`define CODE_TRISTATE 2'b10
`define CODE_GPIO_IN 2'b11

`endif

// >>> test/gpio_bank_chk.sv
// Checker for the pin bank: bus answers and pin states after reset.
// Assumes it is bound to gpio_pin_config_bank.
`timescale 1ns/1ps
`default_nettype none
module gpio_bank_chk (
   input wire logic hclk, // Clock.
   input wire logic hresetn, // Reset, active low.
   input wire logic hsel, // Select.
   input wire logic [31:0] haddr, // Address.
   input wire logic [1:0] htrans, // Transfer type.
   input wire logic hwrite, // Write.
   input wire logic hready, // Bus ready.
   input wire logic hreadyout, // Slave ready.
   input wire logic hresp, // Response.
   input wire logic [31:0] hrdata, // Read data.
   input wire logic [4:0] pin_oe, // Primary enables.
   input wire logic [4:0] alt_pin_oe // Alternate enables.
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   sequence rd_at(logic [31:0] a);
      hsel && hready && htrans[1] && !hwrite && haddr == a;
   endsequence
   sequence rd_unmapped;
      hsel && hready && htrans[1] && !hwrite
         && !(haddr inside {32'h7c, 32'h80, 32'h84, 32'h90, 32'h94});
   endsequence
   ready_const_a: assert property (hreadyout) else $error("hreadyout low");
   resp_okay_a: assert property (!hresp) else $error("hresp not okay");
   rdata_upper_a: assert property (hrdata[31:8] == 24'h0) else $error("hrdata high");
   unmapped_zero_a: assert property (rd_unmapped |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   port_read_a: assert property (rd_at(32'h90) |=> hrdata[31:1] == 31'h0)
      else $error("port control spare bits set");
   status_read_a: assert property (rd_at(32'h94) |=> hrdata[31:5] == 27'h0)
      else $error("status spare bits set");
   prim_reset_a: assert property ($rose(hresetn) |=> pin_oe == 5'h1f)
      else $error("primary pins not functional after reset");
   alt_reset_a: assert property ($rose(hresetn) |=> alt_pin_oe == 5'h1e)
      else $error("alternate pin3 not input after reset");
endmodule
bind gpio_pin_config_bank gpio_bank_chk u_gpio_bank_chk (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_oe(pin_oe),
   .alt_pin_oe(alt_pin_oe));
`default_nettype wire

// >>> test/gpio_remote_model.sv
// Model of the remote serializer that mirrors pin values over the link.
// Assumes the bench drives freeze and preset from the bus clock domain.
`timescale 1ns/1ps
`default_nettype none
module gpio_remote_model (
   input wire logic hclk, // Clock.
   input wire logic hresetn, // Reset, active low.
   input wire logic freeze, // Hold the preset values.
   input wire logic [4:0] preset, // Values to mirror while frozen.
   output logic [4:0] remote_value // Mirrored values.
);
   // Unfrozen values move every cycle, so a stale copy is never taken for a live one.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         remote_value <= 5'h00;
      end else if (freeze) begin
         remote_value <= preset;
      end else begin
         remote_value <= remote_value + 5'h01;
      end
   end
endmodule
`default_nettype wire

// >>> test/tb.sv
// Self-checking bench for the pin configuration bank.
// Assumes the design, remote model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) check(n, 32'(e), 32'(g));
module tb;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [4:0] preset = 5'h1f;
   logic freeze = 1'b1;
   logic [31:0] rdata;
   wire logic hready;
   wire logic hreadyout, hresp;
   wire logic [31:0] hrdata;
   wire logic [4:0] remote_value, pin_out, pin_oe, alt_pin_out, alt_pin_oe;
   int fail_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   assign hready = hreadyout;
   gpio_remote_model u_gpio_remote_model (.hclk(hclk), .hresetn(hresetn), .freeze(freeze),
      .preset(preset), .remote_value(remote_value));
   gpio_pin_config_bank u_gpio_pin_config_bank (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .func_value(5'h1f), .alt_func_value(5'h00), .remote_value(remote_value),
      .pin_in(5'h15), .pin_out(pin_out), .pin_oe(pin_oe), .alt_pin_in(5'h0a),
      .alt_pin_out(alt_pin_out), .alt_pin_oe(alt_pin_oe));
   task automatic conclude();
      if (fail_count == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rdata = hrdata;
   endtask
   task automatic rdchk(input string n, input logic [31:0] a, input logic [31:0] e);
      xfer(a, 1'b0, 32'h0);
      check(n, e, rdata);
   endtask
   task automatic t_reset();
      rdchk("pin3", 32'h7c, 32'h00);
      rdchk("pair56", 32'h80, 32'h00);
      rdchk("pair78", 32'h84, 32'h00);
      `CHK("oe after reset", 5'h1f, pin_oe)
      `CHK("out after reset", 5'h17, pin_out)
      `CHK("alt oe after reset", 5'h1e, alt_pin_oe)
      `CHK("alt out after reset", 5'h00, alt_pin_out)
      xfer(32'h90, 1'b1, 32'h1);
      rdchk("alt pin3", 32'h7c, 32'h03);
      rdchk("port", 32'h90, 32'h01);
      rdchk("status alt", 32'h94, 32'h0a);
      xfer(32'h90, 1'b1, 32'h0);
      rdchk("status", 32'h94, 32'h15);
   endtask
   task automatic t_codes();
      for (int c = 0; c < 4; c++) begin
         xfer(32'h80, 1'b1, 32'(c));
         repeat (2) @(negedge hclk);
         `CHK("pin5 oe", c < 2, pin_oe[1])
         `CHK("pin5 out", c == 0, pin_out[1] & pin_oe[1])
         rdchk("pair56", 32'h80, 32'(c));
      end
   endtask
   task automatic t_remote();
      logic [4:0] mirror;
      @(posedge hclk);
      preset <= 5'h14;
      xfer(32'h80, 1'b1, 32'h74);
      repeat (2) @(negedge hclk);
      `CHK("remote oe", 2'b11, pin_oe[2:1])
      `CHK("remote out", 2'b10, pin_out[2:1])
      @(posedge hclk);
      freeze <= 1'b0;
      repeat (8) begin
         @(negedge hclk);
         mirror = remote_value;
         @(negedge hclk);
         `CHK("remote follow", mirror[2:1], pin_out[2:1])
      end
      @(posedge hclk);
      freeze <= 1'b1;
      xfer(32'h84, 1'b1, 32'h5b);
      repeat (2) @(negedge hclk);
      `CHK("pin7 8 oe", 2'b10, pin_oe[4:3])
      `CHK("pin8 out", 1'b1, pin_out[4])
      rdchk("pair78", 32'h84, 32'h5b);
   endtask
   task automatic t_alt();
      xfer(32'h90, 1'b1, 32'h1);
      xfer(32'h80, 1'b1, 32'h09);
      repeat (2) @(negedge hclk);
      `CHK("alt pin5 oe", 1'b1, alt_pin_oe[1])
      `CHK("alt pin5 out", 1'b1, alt_pin_out[1])
      `CHK("pin5 out", 1'b0, pin_out[1])
      xfer(32'h90, 1'b1, 32'h0);
      rdchk("pair56", 32'h80, 32'h74);
   endtask
   task automatic t_unmapped();
      xfer(32'h200, 1'b1, 32'hff);
      rdchk("unmapped", 32'h200, 32'h0);
      rdchk("misaligned", 32'h81, 32'h0);
      rdchk("pair78 kept", 32'h84, 32'h5b);
   endtask
   task automatic t_rereset();
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rdchk("pair78 reset", 32'h84, 32'h00);
      `CHK("oe after rereset", 5'h1f, pin_oe)
      `CHK("out after rereset", 5'h17, pin_out)
   endtask
   initial begin
      forever #10 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         fail_count++;
         conclude();
      end
   end
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_codes();
      t_remote();
      t_alt();
      t_unmapped();
      t_rereset();
      conclude();
   end
endmodule
`default_nettype wire
